// ===== verilog/mrse_pkg.sv
// shared widths, constants, operation codes and state types of the execution datapath
package mrse_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int MADDR_W = 9;
    localparam int MSB = 7;
    localparam int LSB = 0;
    localparam int NIB = 4;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [12:0] PC_SKIP = 13'h0002;
    localparam logic [8:0] MADDR_RESET = 9'h000;
    localparam logic GIE_RESET = 1'b0;

    // operation codes presented by the decoder of the core
    typedef enum logic [4:0] {
        OP_NO_OPERATION = 5'h00, OP_JUMP = 5'h01,
        OP_MOVE_MEM_TO_ACC = 5'h02, OP_MOVE_LIT_TO_ACC = 5'h03,
        OP_MOVE_ACC_TO_MEM = 5'h04, OP_OR_MEM_TO_ACC = 5'h05,
        OP_OR_LIT_TO_ACC = 5'h06, OP_BITWISE_OR_TO_MEM = 5'h07,
        OP_SUB_RETURN = 5'h08, OP_RETURN_LIT = 5'h09,
        OP_INTERRUPT_RETURN = 5'h0a, OP_ROTATE_LEFT_MEM = 5'h0b,
        OP_ROTATE_LEFT_TO_ACC = 5'h0c, OP_ROTATE_LEFT_THROUGH_CARRY = 5'h0d,
        OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h0e, OP_ROTATE_RIGHT_MEM = 5'h0f,
        OP_ROTATE_RIGHT_TO_ACC = 5'h10, OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h11,
        OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h12, OP_SUBTRACT_BORROW_TO_ACC = 5'h13,
        OP_SUBTRACT_BORROW_TO_MEM = 5'h14, OP_DECREMENT_SKIP_ZERO = 5'h15,
        OP_DECREMENT_SKIP_ZERO_TO_ACC = 5'h16
    } mrse_op_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } mrse_flags_t;

    localparam mrse_flags_t FLAGS_RESET = 4'h0;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b10
    } mrse_state_t;
endpackage

// ===== verilog/mrse_core_if.sv
// carrier between the datapath top and its arithmetic and sequencing modules
`timescale 1ns/1ps
interface mrse_core_if;
    import mrse_pkg::*;
    mrse_op_t op;
    logic [7:0] acc, mem, lit, result;
    logic c_in, dec_zero;
    mrse_flags_t res_flags;
    logic take, jump, pop_req, gie_set, two_cycle, skip;
    logic [12:0] target, stack_top, pc;
    logic ready, discard, pop, gie;

    modport core (output op, acc, mem, lit, c_in, take, jump, pop_req, gie_set,
        two_cycle, skip, target, stack_top,
        input result, res_flags, dec_zero, pc, ready, discard, pop, gie);
    modport alu (input op, acc, mem, lit, c_in, output result, res_flags, dec_zero);
    modport seq (input take, jump, pop_req, gie_set, two_cycle, skip, target,
        stack_top, output pc, ready, discard, pop, gie);
endinterface

// ===== verilog/mrse_alu.sv
// combinational result and flag unit
`timescale 1ns/1ps
module mrse_alu (
    mrse_core_if.alu bus
);
    import mrse_pkg::*;
    logic [8:0] sub_sum;
    logic [4:0] sub_low;
    logic [7:0] dec_val;

    // one result byte per operation; flags default to the carry held
    always_comb begin
        sub_sum = {1'b0, bus.acc} + {1'b0, ~bus.mem} + {8'h00, bus.c_in};
        sub_low = {1'b0, bus.acc[NIB-1:LSB]} + {1'b0, ~bus.mem[NIB-1:LSB]} + {4'h0, bus.c_in};
        dec_val = bus.mem - ONE_BYTE;
        bus.result = ZERO_BYTE;
        bus.res_flags = FLAGS_RESET;
        bus.res_flags.c = bus.c_in;
        unique case (bus.op)
            OP_MOVE_MEM_TO_ACC: bus.result = bus.mem;
            OP_MOVE_LIT_TO_ACC, OP_RETURN_LIT: bus.result = bus.lit;
            OP_MOVE_ACC_TO_MEM: bus.result = bus.acc;
            OP_OR_MEM_TO_ACC, OP_BITWISE_OR_TO_MEM: bus.result = bus.acc | bus.mem;
            OP_OR_LIT_TO_ACC: bus.result = bus.acc | bus.lit;
            OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_ACC: begin
                bus.result = {bus.mem[MSB-1:LSB], bus.mem[MSB]};
            end
            OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                bus.result = {bus.mem[MSB-1:LSB], bus.c_in};
                bus.res_flags.c = bus.mem[MSB];
            end
            OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_ACC: begin
                bus.result = {bus.mem[LSB], bus.mem[MSB:LSB+1]};
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                bus.result = {bus.c_in, bus.mem[MSB:LSB+1]};
                bus.res_flags.c = bus.mem[LSB];
            end
            OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEM: begin
                bus.result = sub_sum[DATA_W-1:0];
                bus.res_flags.c = sub_sum[DATA_W];
                bus.res_flags.ac = sub_low[NIB];
                // overflow when like-signed operands give a result of the other sign
                bus.res_flags.ov = (bus.acc[MSB] == ~bus.mem[MSB])
                    && (sub_sum[MSB] != bus.acc[MSB]);
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_ACC: bus.result = dec_val;
            default: bus.result = ZERO_BYTE;
        endcase
        bus.res_flags.z = (bus.result == ZERO_BYTE);
        bus.dec_zero = (dec_val == ZERO_BYTE);
    end
endmodule

// ===== verilog/mrse_seq.sv
// program counter, return pop, interrupt enable and dummy-cycle sequencer
`timescale 1ns/1ps
module mrse_seq (
    input wire logic clk_in,
    input wire logic reset_in,
    mrse_core_if.seq bus
);
    import mrse_pkg::*;
    typedef struct packed {
        mrse_state_t state;
        logic [12:0] pc;
        logic ready;
        logic discard;
        logic pop;
        logic gie;
    } mrse_seq_t;
    localparam mrse_seq_t SEQ_RESET = '{state: ST_EXEC, pc: PC_RESET, ready: 1'b1,
        discard: 1'b0, pop: 1'b0, gie: GIE_RESET};
    mrse_seq_t seq_reg, seq_next;

    // pops and discards are one-cycle pulses; the dummy cycle refuses new work
    always_comb begin
        seq_next = seq_reg;
        seq_next.discard = 1'b0;
        seq_next.pop = 1'b0;
        unique case (seq_reg.state)
            ST_EXEC: begin
                if (bus.take) begin
                    if (bus.jump) begin
                        seq_next.pc = bus.target;
                    end else if (bus.pop_req) begin
                        seq_next.pc = bus.stack_top;
                    end else if (bus.skip) begin
                        seq_next.pc = seq_reg.pc + PC_SKIP;
                    end else begin
                        seq_next.pc = seq_reg.pc + PC_STEP;
                    end
                    seq_next.pop = bus.pop_req;
                    if (bus.gie_set) begin
                        seq_next.gie = 1'b1;
                    end
                    if (bus.two_cycle || bus.skip) begin
                        seq_next.state = ST_DUMMY;
                        seq_next.ready = 1'b0;
                        seq_next.discard = 1'b1;
                    end
                end
            end
            ST_DUMMY: begin
                seq_next.state = ST_EXEC;
                seq_next.ready = 1'b1;
            end
            default: begin
                seq_next.state = ST_EXEC;
                seq_next.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            seq_reg <= SEQ_RESET;
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign bus.pc = seq_reg.pc;
    assign bus.ready = seq_reg.ready;
    assign bus.discard = seq_reg.discard;
    assign bus.pop = seq_reg.pop;
    assign bus.gie = seq_reg.gie;
endmodule

// ===== verilog/mrse_exec.sv
// execution datapath for moves, OR, returns, rotates, borrow subtract, decrement-skip
// Contract
// - jump loads the program counter from the instruction; flags stay.
// - move memory to accumulator copies the byte; flags stay.
// - immediate move loads the 8-bit literal into the accumulator; flags stay.
// - store writes accumulator to memory; accumulator and flags stay.
// - no-operation only advances the program counter by one.
// - OR with memory or literal into accumulator updates only zero.
// - OR to memory writes the OR back to memory, updates only zero.
// - subroutine return pops the program counter, two cycles, no flag change.
// - return with literal pops the counter and loads the literal; flags stay.
// - interrupt return pops the counter and sets global interrupt enable.
// - rotate left to memory feeds bit 7 into bit 0; carry kept.
// - rotate left to accumulator leaves memory and flags unchanged.
// - rotate left through carry to memory: old carry in, bit 7 out.
// - nine-bit left rotate to accumulator, memory kept, only carry changes.
// - rotate right to memory or accumulator feeds bit 0 into bit 7; no flags.
// - rotate right through carry: old carry to bit 7, bit 0 to carry.
// - borrow subtract to accumulator; updates overflow, zero, aux carry, carry.
// - borrow subtract to memory writes memory; updates the same four flags.
// - decrement-skip writes memory; zero result skips, two cycles, else one.
// - decrement-skip to accumulator keeps memory and skips on zero.
// - a taken skip discards the prefetched word and adds a dummy cycle.
`timescale 1ns/1ps
module mrse_exec (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic OP_VALID_IN,
    input wire mrse_pkg::mrse_op_t OP_CODE_IN,
    input wire logic [mrse_pkg::PC_W-1:0] OP_TARGET_IN,
    input wire logic [mrse_pkg::MADDR_W-1:0] OP_MADDR_IN,
    input wire logic [mrse_pkg::DATA_W-1:0] OP_LIT_IN,
    input wire logic [mrse_pkg::DATA_W-1:0] MEM_RDATA_IN,
    input wire logic [mrse_pkg::PC_W-1:0] STACK_TOP_IN,
    output logic READY_OUT,
    output logic [mrse_pkg::PC_W-1:0] PC_OUT,
    output logic DISCARD_OUT,
    output logic STACK_POP_OUT,
    output logic GLOBAL_INTERRUPT_ENABLE_OUT,
    output logic [mrse_pkg::DATA_W-1:0] ACC_OUT,
    output logic FLAG_OV_OUT,
    output logic FLAG_Z_OUT,
    output logic FLAG_AC_OUT,
    output logic FLAG_C_OUT,
    output logic MEM_WE_OUT,
    output logic [mrse_pkg::MADDR_W-1:0] MEM_WADDR_OUT,
    output logic [mrse_pkg::DATA_W-1:0] MEM_WDATA_OUT
);
    import mrse_pkg::*;

    typedef struct packed {
        logic [7:0] acc;
        mrse_flags_t flags;
        logic mem_we;
        logic [8:0] mem_waddr;
        logic [7:0] mem_wdata;
    } mrse_core_t;
    localparam mrse_core_t CORE_RESET = '{acc: ACC_RESET, flags: FLAGS_RESET,
        mem_we: 1'b0, mem_waddr: MADDR_RESET, mem_wdata: ZERO_BYTE};

    mrse_core_t core_reg, core_next;
    mrse_core_if cif();
    logic take;
    logic is_dec;

    // an instruction is taken only while the sequencer is out of a dummy cycle
    assign take = OP_VALID_IN && READY_OUT;
    assign is_dec = (OP_CODE_IN == OP_DECREMENT_SKIP_ZERO)
        || (OP_CODE_IN == OP_DECREMENT_SKIP_ZERO_TO_ACC);

    // operands toward the result unit; memory byte is read in the issue cycle
    assign cif.op = OP_CODE_IN;
    assign cif.acc = core_reg.acc;
    assign cif.mem = MEM_RDATA_IN;
    assign cif.lit = OP_LIT_IN;
    assign cif.c_in = core_reg.flags.c;

    // control toward the sequencer
    assign cif.take = take;
    assign cif.jump = (OP_CODE_IN == OP_JUMP);
    assign cif.pop_req = (OP_CODE_IN == OP_SUB_RETURN) || (OP_CODE_IN == OP_RETURN_LIT)
        || (OP_CODE_IN == OP_INTERRUPT_RETURN);
    assign cif.gie_set = (OP_CODE_IN == OP_INTERRUPT_RETURN);
    assign cif.two_cycle = (OP_CODE_IN == OP_SUB_RETURN);
    assign cif.skip = is_dec && cif.dec_zero;
    assign cif.target = OP_TARGET_IN;
    assign cif.stack_top = STACK_TOP_IN;

    mrse_alu u_alu (
        .bus(cif.alu)
    );

    mrse_seq u_seq (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .bus(cif.seq)
    );

    // destination and flag-update decode; untouched flags hold by default
    always_comb begin
        logic to_acc;
        logic to_mem;
        logic upd_z;
        logic upd_c;
        logic upd_arith;
        to_acc = 1'b0;
        to_mem = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_arith = 1'b0;
        core_next = core_reg;
        core_next.mem_we = 1'b0;
        unique case (OP_CODE_IN)
            OP_MOVE_MEM_TO_ACC, OP_MOVE_LIT_TO_ACC, OP_RETURN_LIT: begin
                to_acc = 1'b1;
            end
            OP_MOVE_ACC_TO_MEM: to_mem = 1'b1;
            OP_OR_MEM_TO_ACC, OP_OR_LIT_TO_ACC: begin
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            OP_BITWISE_OR_TO_MEM: begin
                to_mem = 1'b1;
                upd_z = 1'b1;
            end
            OP_ROTATE_LEFT_MEM, OP_ROTATE_RIGHT_MEM: to_mem = 1'b1;
            OP_ROTATE_LEFT_TO_ACC, OP_ROTATE_RIGHT_TO_ACC: to_acc = 1'b1;
            OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                to_mem = 1'b1;
                upd_c = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY_TO_ACC, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                to_acc = 1'b1;
                upd_c = 1'b1;
            end
            OP_SUBTRACT_BORROW_TO_ACC: begin
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            OP_SUBTRACT_BORROW_TO_MEM: begin
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            OP_DECREMENT_SKIP_ZERO: to_mem = 1'b1;
            OP_DECREMENT_SKIP_ZERO_TO_ACC: to_acc = 1'b1;
            // jump, returns without data and no-operation touch no data path
            OP_NO_OPERATION, OP_JUMP, OP_SUB_RETURN, OP_INTERRUPT_RETURN: begin
                to_acc = 1'b0;
            end
            default: to_acc = 1'b0;
        endcase
        if (take) begin
            if (to_acc) begin
                core_next.acc = cif.result;
            end
            if (to_mem) begin
                core_next.mem_we = 1'b1;
                core_next.mem_waddr = OP_MADDR_IN;
                core_next.mem_wdata = cif.result;
            end
            if (upd_z) begin
                core_next.flags.z = cif.res_flags.z;
            end
            if (upd_c) begin
                core_next.flags.c = cif.res_flags.c;
            end
            if (upd_arith) begin
                core_next.flags = cif.res_flags;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            core_reg <= CORE_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    // every output is a flop of this module or of the sequencer
    assign ACC_OUT = core_reg.acc;
    assign FLAG_OV_OUT = core_reg.flags.ov;
    assign FLAG_Z_OUT = core_reg.flags.z;
    assign FLAG_AC_OUT = core_reg.flags.ac;
    assign FLAG_C_OUT = core_reg.flags.c;
    assign MEM_WE_OUT = core_reg.mem_we;
    assign MEM_WADDR_OUT = core_reg.mem_waddr;
    assign MEM_WDATA_OUT = core_reg.mem_wdata;
    assign READY_OUT = cif.ready;
    assign PC_OUT = cif.pc;
    assign DISCARD_OUT = cif.discard;
    assign STACK_POP_OUT = cif.pop;
    assign GLOBAL_INTERRUPT_ENABLE_OUT = cif.gie;

    // checks on the executed effect, one cycle after the issue edge
    logic [3:0] flag_bits;
    assign flag_bits = {FLAG_OV_OUT, FLAG_Z_OUT, FLAG_AC_OUT, FLAG_C_OUT};

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    a_jump_target: assert property (
        take && OP_CODE_IN == OP_JUMP
        |=> PC_OUT == $past(OP_TARGET_IN) && $stable(flag_bits))
        else $error("jump did not load target or changed flags");

    a_move_mem_acc: assert property (
        take && OP_CODE_IN == OP_MOVE_MEM_TO_ACC
        |=> ACC_OUT == $past(MEM_RDATA_IN) && $stable(flag_bits))
        else $error("memory move to accumulator wrong");

    a_move_lit_acc: assert property (
        take && OP_CODE_IN == OP_MOVE_LIT_TO_ACC
        |=> ACC_OUT == $past(OP_LIT_IN) && $stable(flag_bits))
        else $error("literal move to accumulator wrong");

    a_store_acc_mem: assert property (
        take && OP_CODE_IN == OP_MOVE_ACC_TO_MEM
        |=> MEM_WE_OUT && MEM_WDATA_OUT == $past(ACC_OUT)
            && MEM_WADDR_OUT == $past(OP_MADDR_IN)
            && $stable(ACC_OUT) && $stable(flag_bits))
        else $error("accumulator store wrong");

    a_nop_advance: assert property (
        take && OP_CODE_IN == OP_NO_OPERATION
        |=> PC_OUT == $past(PC_OUT) + PC_STEP && !MEM_WE_OUT
            && $stable(ACC_OUT) && $stable(flag_bits))
        else $error("no-operation changed state");

    a_or_zero_only: assert property (
        take && OP_CODE_IN == OP_OR_MEM_TO_ACC
        |=> ACC_OUT == ($past(ACC_OUT) | $past(MEM_RDATA_IN))
            && FLAG_Z_OUT == (ACC_OUT == ZERO_BYTE)
            && $stable(FLAG_C_OUT) && $stable(FLAG_AC_OUT) && $stable(FLAG_OV_OUT))
        else $error("OR to accumulator wrong");

    a_or_mem_write: assert property (
        take && OP_CODE_IN == OP_BITWISE_OR_TO_MEM
        |=> MEM_WE_OUT && MEM_WDATA_OUT == ($past(ACC_OUT) | $past(MEM_RDATA_IN))
            && FLAG_Z_OUT == (MEM_WDATA_OUT == ZERO_BYTE) && $stable(ACC_OUT))
        else $error("OR to memory wrong");

    a_return_two_cycle: assert property (
        take && OP_CODE_IN == OP_SUB_RETURN
        |=> !READY_OUT && DISCARD_OUT && STACK_POP_OUT
            && PC_OUT == $past(STACK_TOP_IN) && $stable(flag_bits)
        ##1 READY_OUT && !STACK_POP_OUT)
        else $error("subroutine return not two cycles");

    a_return_lit: assert property (
        take && OP_CODE_IN == OP_RETURN_LIT
        |=> ACC_OUT == $past(OP_LIT_IN) && PC_OUT == $past(STACK_TOP_IN)
            && STACK_POP_OUT && $stable(flag_bits))
        else $error("return with literal wrong");

    a_int_return_gie: assert property (
        take && OP_CODE_IN == OP_INTERRUPT_RETURN
        |=> GLOBAL_INTERRUPT_ENABLE_OUT && STACK_POP_OUT
            && PC_OUT == $past(STACK_TOP_IN))
        else $error("interrupt return did not re-enable");

    a_rotate_left_mem: assert property (
        take && OP_CODE_IN == OP_ROTATE_LEFT_MEM
        |=> MEM_WE_OUT && $stable(flag_bits)
            && {MEM_WDATA_OUT[LSB], MEM_WDATA_OUT[MSB:LSB+1]} == $past(MEM_RDATA_IN))
        else $error("left rotate to memory wrong");

    a_rotate_carry_acc: assert property (
        take && OP_CODE_IN == OP_ROTATE_LEFT_CARRY_TO_ACC
        |=> {FLAG_C_OUT, ACC_OUT} == {$past(MEM_RDATA_IN), $past(FLAG_C_OUT)}
            && !MEM_WE_OUT && $stable(FLAG_Z_OUT))
        else $error("left rotate through carry to accumulator wrong");

    a_rotate_right_carry: assert property (
        take && OP_CODE_IN == OP_ROTATE_RIGHT_CARRY_TO_ACC
        |=> {ACC_OUT, FLAG_C_OUT} == {$past(FLAG_C_OUT), $past(MEM_RDATA_IN)})
        else $error("right rotate through carry wrong");

    a_borrow_sub_acc: assert property (
        take && OP_CODE_IN == OP_SUBTRACT_BORROW_TO_ACC
        |=> {FLAG_C_OUT, ACC_OUT} == ({1'b0, $past(ACC_OUT)}
            + {1'b0, ~$past(MEM_RDATA_IN)} + {8'h00, $past(FLAG_C_OUT)})
            && FLAG_Z_OUT == (ACC_OUT == ZERO_BYTE))
        else $error("borrow subtract result wrong");

    a_rotate_left_acc: assert property (
        take && OP_CODE_IN == OP_ROTATE_LEFT_TO_ACC
        |=> {ACC_OUT[LSB], ACC_OUT[MSB:LSB+1]} == $past(MEM_RDATA_IN)
            && !MEM_WE_OUT && $stable(flag_bits))
        else $error("left rotate to accumulator wrong");

    a_rotate_carry_mem: assert property (
        take && OP_CODE_IN == OP_ROTATE_LEFT_THROUGH_CARRY
        |=> MEM_WE_OUT && $stable(ACC_OUT) && $stable(FLAG_Z_OUT)
            && {FLAG_C_OUT, MEM_WDATA_OUT} == {$past(MEM_RDATA_IN), $past(FLAG_C_OUT)})
        else $error("left rotate through carry to memory wrong");

    a_rotate_right_mem: assert property (
        take && OP_CODE_IN == OP_ROTATE_RIGHT_MEM
        |=> MEM_WE_OUT && $stable(flag_bits) && $stable(ACC_OUT)
            && {MEM_WDATA_OUT[MSB-1:LSB], MEM_WDATA_OUT[MSB]} == $past(MEM_RDATA_IN))
        else $error("right rotate to memory wrong");

    a_rotate_right_acc: assert property (
        take && OP_CODE_IN == OP_ROTATE_RIGHT_TO_ACC
        |=> {ACC_OUT[MSB-1:LSB], ACC_OUT[MSB]} == $past(MEM_RDATA_IN) && !MEM_WE_OUT)
        else $error("right rotate to accumulator wrong");

    a_borrow_sub_mem: assert property (
        take && OP_CODE_IN == OP_SUBTRACT_BORROW_TO_MEM
        |=> MEM_WE_OUT && $stable(ACC_OUT)
            && {FLAG_C_OUT, MEM_WDATA_OUT} == ({1'b0, $past(ACC_OUT)}
            + {1'b0, ~$past(MEM_RDATA_IN)} + {8'h00, $past(FLAG_C_OUT)})
            && FLAG_Z_OUT == (MEM_WDATA_OUT == ZERO_BYTE))
        else $error("borrow subtract to memory wrong");

    a_or_lit_acc: assert property (
        take && OP_CODE_IN == OP_OR_LIT_TO_ACC
        |=> ACC_OUT == ($past(ACC_OUT) | $past(OP_LIT_IN)) && !MEM_WE_OUT
            && FLAG_Z_OUT == (ACC_OUT == ZERO_BYTE) && $stable(FLAG_C_OUT))
        else $error("OR literal to accumulator wrong");

    a_skip_dummy: assert property (
        take && OP_CODE_IN == OP_DECREMENT_SKIP_ZERO && MEM_RDATA_IN == ONE_BYTE
        |=> DISCARD_OUT && !READY_OUT && MEM_WE_OUT && MEM_WDATA_OUT == ZERO_BYTE
            && PC_OUT == $past(PC_OUT) + PC_SKIP && $stable(flag_bits)
        ##1 READY_OUT && !DISCARD_OUT)
        else $error("taken skip has no dummy cycle");

    a_no_skip_one: assert property (
        take && is_dec && MEM_RDATA_IN != ONE_BYTE
        |=> READY_OUT && !DISCARD_OUT && PC_OUT == $past(PC_OUT) + PC_STEP)
        else $error("untaken skip not one cycle");

    a_dec_acc_keep: assert property (
        take && OP_CODE_IN == OP_DECREMENT_SKIP_ZERO_TO_ACC
        |=> ACC_OUT == $past(MEM_RDATA_IN) - ONE_BYTE && !MEM_WE_OUT)
        else $error("decrement to accumulator wrong");

    a_flags_idle: assert property (
        !take |=> $stable(flag_bits) && !MEM_WE_OUT && $stable(ACC_OUT))
        else $error("state changed without an instruction");
endmodule

// ===== testbench/test_mcu_move_rotate_sub_exec.sv
// self-checking bench of the move, rotate, borrow-subtract and decrement-skip datapath
`timescale 1ns/1ps
module test_mcu_move_rotate_sub_exec;
    import mrse_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    mrse_op_t op = OP_NO_OPERATION;
    logic [12:0] target = '0, stack = '0, pc_o;
    logic [8:0] maddr = '0, waddr;
    logic [7:0] lit = '0, mdat = '0, acc_o, wdata;
    logic ready, discard, pop, gie, ov, z, ac, c, we;
    // expected architectural state, advanced only by the bench model
    logic [7:0] e_acc = 8'h00, e_wd = 8'h00;
    logic [12:0] e_pc = 13'h0000;
    mrse_flags_t e_f = FLAGS_RESET;
    logic e_gie = 1'b0, e_we = 1'b0, e_pop = 1'b0, e_two = 1'b0;
    int mismatches = 0, compares = 0, cycles = 0;

    always #2 clk = ~clk;

    mrse_exec i_dut (.CLK_IN(clk), .RESET_IN(rst), .OP_VALID_IN(valid), .OP_CODE_IN(op),
        .OP_TARGET_IN(target), .OP_MADDR_IN(maddr), .OP_LIT_IN(lit), .MEM_RDATA_IN(mdat),
        .STACK_TOP_IN(stack), .READY_OUT(ready), .PC_OUT(pc_o), .DISCARD_OUT(discard),
        .STACK_POP_OUT(pop), .GLOBAL_INTERRUPT_ENABLE_OUT(gie), .ACC_OUT(acc_o),
        .FLAG_OV_OUT(ov), .FLAG_Z_OUT(z), .FLAG_AC_OUT(ac), .FLAG_C_OUT(c),
        .MEM_WE_OUT(we), .MEM_WADDR_OUT(waddr), .MEM_WDATA_OUT(wdata));

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // a hang in the sequence would otherwise never reach the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    // works out the effect of the presented operation on the expected state
    task automatic predict();
        logic [8:0] s;
        logic [4:0] lo;
        logic [7:0] r;
        r = 8'h00;
        e_pop = 1'b0;
        e_two = 1'b0;
        e_pc = e_pc + PC_STEP;
        case (op)
            OP_JUMP: e_pc = target;
            OP_MOVE_MEM_TO_ACC: r = mdat;
            OP_MOVE_LIT_TO_ACC, OP_RETURN_LIT: r = lit;
            OP_MOVE_ACC_TO_MEM: r = e_acc;
            OP_OR_LIT_TO_ACC: r = e_acc | lit;
            OP_OR_MEM_TO_ACC, OP_BITWISE_OR_TO_MEM: r = e_acc | mdat;
            OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_ACC: r = {mdat[6:0], mdat[7]};
            OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                r = {mdat[6:0], e_f.c};
                e_f.c = mdat[7];
            end
            OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_ACC: r = {mdat[0], mdat[7:1]};
            OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                r = {e_f.c, mdat[7:1]};
                e_f.c = mdat[0];
            end
            OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEM: begin
                s = {1'b0, e_acc} + {1'b0, ~mdat} + {8'h00, e_f.c};
                lo = {1'b0, e_acc[3:0]} + {1'b0, ~mdat[3:0]} + {4'h0, e_f.c};
                r = s[7:0];
                e_f.ov = (e_acc[7] == ~mdat[7]) && (r[7] != e_acc[7]);
                e_f.ac = lo[4];
                e_f.c = s[8];
                e_f.z = (r == ZERO_BYTE);
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
                r = mdat - ONE_BYTE;
                e_two = (r == ZERO_BYTE);
                e_pc = e_pc + {12'h000, e_two};
            end
            default: ;
        endcase
        // OR only touches zero; every other flag stays put
        if (op inside {OP_OR_LIT_TO_ACC, OP_OR_MEM_TO_ACC, OP_BITWISE_OR_TO_MEM}) begin
            e_f.z = (r == ZERO_BYTE);
        end
        if (op inside {OP_SUB_RETURN, OP_RETURN_LIT, OP_INTERRUPT_RETURN}) begin
            e_pc = stack;
            e_pop = 1'b1;
        end
        e_two = e_two | (op == OP_SUB_RETURN);
        e_gie = e_gie | (op == OP_INTERRUPT_RETURN);
        e_we = op inside {OP_MOVE_ACC_TO_MEM, OP_BITWISE_OR_TO_MEM, OP_ROTATE_LEFT_MEM,
            OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_THROUGH_CARRY,
            OP_SUBTRACT_BORROW_TO_MEM, OP_DECREMENT_SKIP_ZERO};
        e_wd = r;
        if (!e_we && !(op inside {OP_NO_OPERATION, OP_JUMP, OP_SUB_RETURN,
            OP_INTERRUPT_RETURN})) begin
            e_acc = r;
        end
    endtask

    task automatic check_all();
        chk("acc", e_acc, acc_o);
        chk("pc", e_pc, pc_o);
        chk("flags", e_f, {ov, z, ac, c});
        chk("gie", e_gie, gie);
        chk("mem_we", e_we, we);
        chk("pop", e_pop, pop);
        chk("discard", e_two, discard);
        chk("ready", !e_two, ready);
        if (e_we) chk("wdata", e_wd, wdata);
        if (e_we) chk("waddr", maddr, waddr);
    endtask

    // an operation offered with valid low must change nothing
    task automatic idle();
        valid = 1'b0;
        op = mrse_op_t'($urandom_range(22));
        mdat = 8'($urandom);
        e_we = 1'b0;
        e_pop = 1'b0;
        e_two = 1'b0;
        @(negedge clk);
        check_all();
    endtask

    // issues one operation at a falling edge and checks it one cycle later
    task automatic step(input mrse_op_t o, input logic [7:0] m);
        op = o;
        mdat = m;
        lit = 8'($urandom);
        target = 13'($urandom);
        stack = 13'($urandom);
        maddr = 9'($urandom);
        valid = 1'b1;
        predict();
        @(negedge clk);
        check_all();
        if (e_two) begin
            // an offer during the dummy cycle must be ignored
            op = OP_MOVE_LIT_TO_ACC;
            lit = ~e_acc;
            e_we = 1'b0;
            e_pop = 1'b0;
            e_two = 1'b0;
            @(negedge clk);
            check_all();
        end
    endtask

    initial begin
        logic [7:0] corner [4] = '{8'h01, 8'h00, 8'h80, 8'hff};
        void'($urandom(65315));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check_all();
        // every code against boundary bytes, then a random mix with an idle cycle before about one step in four
        foreach (corner[k]) begin
            for (int i = 0; i <= 22; i++) begin
                step(mrse_op_t'(i), corner[k]);
            end
        end
        repeat (600) begin
            if ($urandom_range(3) == 0) idle();
            step(mrse_op_t'($urandom_range(22)), 8'($urandom));
        end
        tally_and_finish();
    end
endmodule
